// ===== rtl/rcst_counter.v
// down counter used for each start-up delay
`timescale 1ns/1ps
`default_nettype none
module rcst_counter #(
    parameter W = 22
) (
    input wire clk_sys, // system clock
    input wire resetn, // sync reset, active low
    input wire ce, // clock enable
    input wire start, // load and begin counting
    input wire [W-1:0] load, // cycles to count
    output reg busy // high while counting
);
    reg [W-1:0] count;
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            count <= {W{1'b0}};
            busy <= 1'b0;
        end
        else if (ce)
        begin
            if (start)
            begin
                count <= load;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (count <= {{(W-1){1'b0}}, 1'b1})
                    busy <= 1'b0;
                count <= count - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // rcst_counter
`default_nettype wire

// ===== rtl/rcst_defs.vh
// constants for reset cause recording and start-up time-out
`ifndef RCST_DEFS_VH
`define RCST_DEFS_VH
// register indices on the plain port
`define RCST_ADDR_FLAGS 2'h0
`define RCST_ADDR_STATUS 2'h1
`define RCST_ADDR_CTRL 2'h2
`define RCST_ADDR_PC 2'h3
// reset_cause_flags fields
`define RCST_BIT_BROWNOUT 0
`define RCST_BIT_POWERON 1
// status register fields
`define RCST_BIT_PD 3
`define RCST_BIT_TO 4
// ctrl register fields
`define RCST_BIT_BOR_EN 0
`define RCST_BIT_PWRT_EN_N 1
`define RCST_BIT_RC_MODE 2
`define RCST_BIT_GIE 3
// reset values
`define RCST_STATUS_POR 8'h18
`define RCST_CTRL_RESET 8'h01
// program counter targets
`define RCST_RESET_VECTOR 13'h0000
`define RCST_IRQ_VECTOR 13'h0004
// timing
`define RCST_CLK_HZ 50000000
`define RCST_PWRT_MS 72
`define RCST_PWRT_CYCLES ((`RCST_PWRT_MS * (`RCST_CLK_HZ / 1000)))
`define RCST_OST_PERIODS 1024
`endif

// ===== rtl/rcst_top.v
// reset cause recording and start-up time-out sequencer
// What this block does
// [RQ1] brown-out reset clears flag bit zero
// [RQ2] software sets brown-out flag after power-on
// [RQ3] brown-out flag meaningless when detector disabled
// [RQ4] power-on clears flag bit one only
// [RQ5] software sets power-on flag after power-on
// [RQ6] delays: 72 ms plus 1024 periods
// [RQ7] power-on sets timeout, powerdown, clears upper
// [RQ8] encode brown-out, watchdog reset, watchdog wake
// [RQ9] master-clear and interrupt wake cause encoding
// [RQ10] resets vector zero, wake resumes next
// [RQ11] interrupt wake with enable uses vector four
// [RQ12] power-up delay first, then oscillator count
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rcst_defs.vh"
module rcst_top #(
    parameter PWRT_CYCLES = `RCST_PWRT_CYCLES,
    parameter OST_PERIODS = `RCST_OST_PERIODS,
    parameter OSC_DIV = 1
) (
    input wire clk_sys, // system clock, 50 MHz
    input wire resetn, // sync reset, active low
    input wire ce, // clock enable, freezes state when low
    input wire ev_poweron, // pulse: power-on reset event
    input wire ev_brownout, // pulse: brown-out detected
    input wire ev_wdt_reset, // pulse: watchdog reset while running
    input wire ev_wdt_wake, // pulse: watchdog wake from sleep
    input wire ev_master_clear_pin, // pulse: master_clear_pin reset
    input wire ev_irq_wake, // pulse: interrupt wake from sleep
    input wire sleeping, // level: core is in sleep
    input wire [12:0] sleep_pc, // address of the sleep instruction
    input wire [1:0] addr, // register index
    input wire [7:0] wdata, // write data
    input wire wr, // write strobe
    input wire rd, // read strobe
    output reg [7:0] rdata, // read data, one cycle after rd
    output reg core_reset, // internal reset held to the core
    output reg [12:0] pc_load, // address to resume at
    output reg pc_load_valid // pulse: pc_load is to be taken
);
    localparam ST_RUN = 2'h0;
    localparam ST_PWRT = 2'h1;
    localparam ST_OST = 2'h2;
    localparam ST_START = 2'h3;

    reg [1:0] state;
    reg [1:0] flags; // {poweron_flag_n, brownout_flag_n}
    reg [7:0] status;
    reg [7:0] ctrl;
    reg need_pwrt;
    reg need_ost;
    reg [12:0] next_pc;
    reg pwrt_start;
    reg ost_start;
    wire pwrt_busy;
    wire ost_busy;
    wire bor_en = ctrl[`RCST_BIT_BOR_EN];
    wire pwrt_en = ~ctrl[`RCST_BIT_PWRT_EN_N];
    wire rc_mode = ctrl[`RCST_BIT_RC_MODE];
    wire global_irq_enable = ctrl[`RCST_BIT_GIE];
    wire brownout = ev_brownout & bor_en;
    wire sw_wr_flags = ce & wr & (addr == `RCST_ADDR_FLAGS);

    //--------------------------------------------------
    // start-up delay counters
    //--------------------------------------------------
    rcst_counter #(.W(32)) u_pwrt (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .start(pwrt_start),
        .load(PWRT_CYCLES),
        .busy(pwrt_busy)
    );
    rcst_counter #(.W(32)) u_ost (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .start(ost_start),
        .load(OST_PERIODS * OSC_DIV),
        .busy(ost_busy)
    );

    //--------------------------------------------------
    // cause capture and sequencing
    //--------------------------------------------------
    always @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state <= ST_RUN;
            flags <= 2'h0;
            status <= `RCST_STATUS_POR;
            ctrl <= `RCST_CTRL_RESET;
            need_pwrt <= 1'b0;
            need_ost <= 1'b0;
            next_pc <= `RCST_RESET_VECTOR;
            pwrt_start <= 1'b0;
            ost_start <= 1'b0;
            core_reset <= 1'b1;
            pc_load <= `RCST_RESET_VECTOR;
            pc_load_valid <= 1'b0;
            rdata <= 8'h00;
        end
        else if (ce)
        begin
            pwrt_start <= 1'b0;
            ost_start <= 1'b0;
            pc_load_valid <= 1'b0;
            rdata <= 8'h00;
            if (rd)
            begin
                case (addr)
                    `RCST_ADDR_FLAGS: rdata <= {6'h00, flags};
                    `RCST_ADDR_STATUS: rdata <= status;
                    `RCST_ADDR_CTRL: rdata <= ctrl;
                    default: rdata <= {3'h0, state, 2'h0, core_reset};
                endcase
            end
            if (wr && addr == `RCST_ADDR_CTRL)
                ctrl <= wdata;
            if (wr && addr == `RCST_ADDR_STATUS)
                status <= {wdata[7:5], status[4:3], wdata[2:0]};
            // software sets flags; a hardware clear below wins
            if (sw_wr_flags)
                flags <= wdata[1:0]; // RQ2 RQ5
            if (ev_poweron)
            begin
                flags[`RCST_BIT_POWERON] <= 1'b0; // RQ4
                status <= `RCST_STATUS_POR; // RQ7
                need_pwrt <= pwrt_en | rc_mode; // RQ6
                need_ost <= ~rc_mode;
                next_pc <= `RCST_RESET_VECTOR; // RQ10
                core_reset <= 1'b1;
                state <= ST_START;
            end
            else if (brownout)
            begin
                flags[`RCST_BIT_BROWNOUT] <= 1'b0; // RQ1 RQ3
                status[`RCST_BIT_TO] <= 1'b1; // RQ8
                status[`RCST_BIT_PD] <= 1'b1;
                status[7:5] <= 3'h0;
                need_pwrt <= 1'b1; // RQ6
                need_ost <= ~rc_mode;
                next_pc <= `RCST_RESET_VECTOR;
                core_reset <= 1'b1;
                state <= ST_START;
            end
            else if (ev_wdt_reset || ev_master_clear_pin)
            begin
                if (ev_wdt_reset)
                begin
                    status[`RCST_BIT_TO] <= 1'b0; // RQ8
                    status[`RCST_BIT_PD] <= 1'b1;
                end
                else if (sleeping)
                begin
                    status[`RCST_BIT_TO] <= 1'b1; // RQ9
                    status[`RCST_BIT_PD] <= 1'b0;
                end
                status[7:5] <= 3'h0;
                need_pwrt <= 1'b0;
                need_ost <= 1'b0;
                next_pc <= `RCST_RESET_VECTOR; // RQ10
                core_reset <= 1'b1;
                state <= ST_START;
            end
            else if (sleeping && (ev_wdt_wake || ev_irq_wake))
            begin
                status[`RCST_BIT_TO] <= ev_irq_wake; // RQ8 RQ9
                status[`RCST_BIT_PD] <= 1'b0;
                need_pwrt <= 1'b0;
                need_ost <= ~rc_mode; // RQ6
                if (ev_irq_wake && global_irq_enable)
                    next_pc <= `RCST_IRQ_VECTOR; // RQ11
                else
                    next_pc <= sleep_pc + 13'h0001; // RQ10
                state <= ST_START;
            end
            else
            begin
                case (state)
                    ST_START:
                    begin
                        // power-up delay first, oscillator count after
                        if (need_pwrt)
                        begin
                            pwrt_start <= 1'b1; // RQ12
                            state <= ST_PWRT;
                        end
                        else if (need_ost)
                        begin
                            ost_start <= 1'b1;
                            state <= ST_OST;
                        end
                        else
                        begin
                            core_reset <= 1'b0;
                            pc_load <= next_pc;
                            pc_load_valid <= 1'b1;
                            state <= ST_RUN;
                        end
                    end
                    ST_PWRT:
                    begin
                        if (!pwrt_start && !pwrt_busy)
                        begin
                            need_pwrt <= 1'b0; // RQ12
                            state <= ST_START;
                        end
                    end
                    ST_OST:
                    begin
                        if (!ost_start && !ost_busy)
                        begin
                            need_ost <= 1'b0; // RQ6
                            state <= ST_START;
                        end
                    end
                    default: state <= ST_RUN;
                endcase
            end
        end
    end
endmodule // rcst_top
`default_nettype wire

// ===== test/rcst_monitor.sv
// port checker for the reset cause sequencer
`timescale 1ns/1ps
`default_nettype none
module rcst_monitor #(
    parameter PWRT_CYCLES = 20,
    parameter OST_PERIODS = 8,
    parameter OSC_DIV = 1
) (
    input wire clk_sys, // clock
    input wire resetn, // reset, low
    input wire ev_poweron, // event
    input wire ev_brownout, // event
    input wire ev_wdt_reset, // event
    input wire ev_wdt_wake, // event
    input wire ev_master_clear_pin, // event
    input wire ev_irq_wake, // event
    input wire sleeping, // core asleep
    input wire [12:0] sleep_pc, // sleep address
    input wire rd, // read strobe
    input wire [7:0] rdata, // read data
    input wire core_reset, // core held
    input wire [12:0] pc_load, // resume address
    input wire pc_load_valid // resume pulse
);
default clocking cb @(posedge clk_sys); endclocking
default disable iff (!resetn);
chk_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not idle");
chk_valid_pulse: assert property (pc_load_valid |=> !pc_load_valid)
    else $error("resume pulse too long");
chk_release_pair: assert property (
    $fell(core_reset) |-> pc_load_valid)
    else $error("release without address");
chk_por_hold: assert property (
    ev_poweron |=> core_reset [*8])
    else $error("power-on released too early");
chk_rise_cause: assert property (
    $rose(core_reset) |->
    $past(ev_poweron || ev_brownout || ev_wdt_reset || ev_master_clear_pin))
    else $error("core reset without cause");
chk_wdt_vector: assert property (
    ev_wdt_reset |-> ##[1:4] (pc_load_valid && pc_load == 13'h0000))
    else $error("watchdog reset vector");
chk_master_clear_pin_vector: assert property (
    ev_master_clear_pin |-> ##[1:40] (pc_load_valid && pc_load == 13'h0000))
    else $error("master clear vector");
chk_wake_resume: assert property (
    ev_wdt_wake && sleeping |-> ##[1:30]
    (pc_load_valid && pc_load == sleep_pc + 13'h0001))
    else $error("watchdog wake address");
chk_irq_target: assert property (
    ev_irq_wake && sleeping |-> ##[1:30] (pc_load_valid &&
    (pc_load == sleep_pc + 13'h0001 || pc_load == 13'h0004)))
    else $error("interrupt wake address");
chk_wake_no_hold: assert property (
    ev_wdt_wake && sleeping && !core_reset |=> !core_reset [*4])
    else $error("wake held the core");
cover property (ev_poweron ##[1:60] pc_load_valid);
cover property (ev_irq_wake && sleeping);
cover property ($fell(core_reset));
endmodule // rcst_monitor
bind rcst_top rcst_monitor #(.PWRT_CYCLES(PWRT_CYCLES),
    .OST_PERIODS(OST_PERIODS), .OSC_DIV(OSC_DIV)) i_rcst_monitor (
    .clk_sys(clk_sys), .resetn(resetn), .ev_poweron(ev_poweron),
    .ev_brownout(ev_brownout), .ev_wdt_reset(ev_wdt_reset),
    .ev_wdt_wake(ev_wdt_wake), .ev_master_clear_pin(ev_master_clear_pin),
    .ev_irq_wake(ev_irq_wake), .sleeping(sleeping),
    .sleep_pc(sleep_pc), .rd(rd), .rdata(rdata),
    .core_reset(core_reset), .pc_load(pc_load),
    .pc_load_valid(pc_load_valid));
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the reset cause sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
localparam int PW = 20;
localparam int OS = 8;
reg clk_sys = 1'b0;
reg resetn = 1'b0;
reg [5:0] ev = 6'h00; // por, bor, wdt, wake, master_clear_pin, irq
reg sleeping = 1'b0;
reg [12:0] sleep_pc = 13'h0123;
reg [1:0] addr = 2'h0;
reg [7:0] wdata = 8'h00;
reg wr = 1'b0;
reg rd = 1'b0;
reg ce = 1'b1;
wire [7:0] rdata;
wire core_reset;
wire pc_load_valid;
wire [12:0] pc_load;
int miscompares = 0;
int n_checks = 0;
int cyc = 0;
always #10 clk_sys = ~clk_sys;
rcst_top #(.PWRT_CYCLES(PW), .OST_PERIODS(OS), .OSC_DIV(1)) i_rcst_top (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .ev_poweron(ev[0]),
    .ev_brownout(ev[1]), .ev_wdt_reset(ev[2]), .ev_wdt_wake(ev[3]),
    .ev_master_clear_pin(ev[4]), .ev_irq_wake(ev[5]), .sleeping(sleeping),
    .sleep_pc(sleep_pc), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .core_reset(core_reset), .pc_load(pc_load),
    .pc_load_valid(pc_load_valid));
task automatic stop_test;
    if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task automatic chk(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
        miscompares++;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
endtask
task automatic wreg(input [1:0] a, input [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
endtask
task automatic rreg(input [1:0] a, input [7:0] e, input [7:0] m = 8'hFF);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    @(negedge clk_sys);
    chk(rdata & m, e);
endtask
// pulse one event, time the release and check the address
task automatic go(input int k, input [12:0] pc, input int lo, input int hi);
    int n;
    n = 0;
    @(posedge clk_sys);
    ev <= 6'h01 << k;
    @(posedge clk_sys);
    ev <= 6'h00;
    @(negedge clk_sys);
    while (pc_load_valid !== 1'b1 && n < 300)
    begin
        @(negedge clk_sys);
        n++;
    end
    chk(pc_load, pc);
    chk(n >= lo && n <= hi, 1);
    chk(core_reset, 0);
endtask
always @(posedge clk_sys)
begin
    cyc++;
    if (cyc == 5000)
    begin
        miscompares++;
        $display("[ERR] %0t timeout", $time);
        stop_test;
    end
end
initial
begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rreg(0, 8'h00);
    rreg(1, 8'h18);
    rreg(2, 8'h01);
    rreg(3, 8'h01, 8'h01);
    go(0, 0, PW + OS, PW + OS + 12);
    rreg(1, 8'h18);
    rreg(0, 8'h00, 8'h02);
    wreg(0, 8'h03);
    wreg(1, 8'hE5);
    rreg(1, 8'hFD);
    go(1, 0, PW + OS, PW + OS + 12);
    rreg(0, 8'h02);
    rreg(1, 8'h1D);
    wreg(0, 8'h03);
    wreg(1, 8'hE5);
    go(2, 0, 1, 4);
    rreg(1, 8'h0D);
    rreg(0, 8'h03);
    wreg(1, 8'hE5);
    go(4, 0, 1, 4);
    rreg(1, 8'h0D);
    @(posedge clk_sys);
    sleeping <= 1'b1;
    wreg(1, 8'hE5);
    go(3, 13'h0124, OS, OS + 11);
    rreg(1, 8'hE5);
    go(5, 13'h0124, OS, OS + 11);
    rreg(1, 8'hF5);
    wreg(2, 8'h09);
    go(5, 13'h0004, OS, OS + 11);
    go(4, 0, 1, 40);
    rreg(1, 8'h15);
    @(posedge clk_sys);
    sleeping <= 1'b0;
    wreg(2, 8'h05);
    go(1, 0, PW, PW + 7);
    wreg(2, 8'h03);
    go(0, 0, OS, OS + 11);
    go(1, 0, PW + OS, PW + OS + 12);
    @(posedge clk_sys);
    ce <= 1'b0;
    wreg(2, 8'h0F);
    ce <= 1'b1;
    rreg(2, 8'h03);
    wreg(3, 8'hFF);
    rreg(3, 8'h00, 8'h01);
    stop_test;
end
endmodule // tb
`default_nettype wire
